// [logic/vdig_pkg.sv]
package vdig_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_REVISION     = 6'h00;
  localparam logic [5:0] IDX_DIV_HIGH     = 6'h01;
  localparam logic [5:0] IDX_DIV_LOW      = 6'h02;
  localparam logic [5:0] IDX_CLKGEN       = 6'h03;
  localparam logic [5:0] IDX_SYNC_STATUS  = 6'h14;
  localparam logic [5:0] IDX_OUT_MODE     = 6'h15;
  localparam logic [5:0] IDX_TEST_CFG_A   = 6'h16;
  localparam logic [5:0] IDX_TEST_CFG_B   = 6'h17;
  localparam logic [5:0] IDX_TEST_STAT_A  = 6'h18;
  localparam logic [5:0] IDX_TEST_STAT_B  = 6'h19;

  // Reset values.
  localparam logic [11:0] DIV_VALUE_RESET = 12'h69D;
  localparam logic [7:0]  DIV_HIGH_RESET  = 8'h69;
  localparam logic [3:0]  DIV_SPARE_RESET = 4'h0;
  localparam logic [7:0]  CLKGEN_RESET    = 8'h48;
  localparam logic [7:0]  OUT_MODE_RESET  = 8'hC6;
  localparam logic [7:0]  TEST_A_RESET    = 8'hFF;
  localparam logic [4:0]  TEST_B_RESET    = 5'h00;

  // Field positions.
  localparam int DIV_LOW_LSB   = 4;
  localparam int RANGE_LSB     = 6;
  localparam int PUMP_LSB      = 3;
  localparam int TEST_B_LSB    = 3;
  localparam int MODE_DUAL     = 7;
  localparam int MODE_PARALLEL = 6;
  localparam int MODE_PORT_B   = 5;
  localparam int MODE_EXT_CLK  = 0;

  // Supported operational divide ratios.
  localparam logic [12:0] RATIO_MIN = 13'h0002;
  localparam logic [12:0] RATIO_MAX = 13'h0FFF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic hsync_present;
    logic active_hsync_source;
    logic hsync_polarity_high;
    logic vsync_present;
    logic active_vsync_source;
    logic vsync_out_polarity_low;
    logic green_sync_present;
    logic coast_polarity_high;
  } sync_status_t;

  typedef struct packed {
    logic [12:0] divide_ratio;
    logic        ratio_in_range;
    logic [1:0]  oscillator_range_field;
    logic [1:0]  post_divide_sel;
    logic [9:0]  pump_current_ua;
    logic        internal_loop_off;
  } clock_gen_cfg_t;

  typedef struct packed {
    logic dual_channel;
    logic parallel_out;
    logic first_port_b;
  } output_mode_t;

endpackage

// [logic/video_digitizer_control_regs.sv]
`timescale 1ns/1ps
// Contract
// - Status bit 7 shows horizontal sync present.
// - Status bit 6 shows horizontal sync source.
// - Status bit 5 shows horizontal sync polarity.
// - Status bit 4 shows vertical sync present.
// - Status bit 3 shows vertical sync source.
// - Status bit 2 shows output vertical polarity.
// - Status bit 1 shows green sync present.
// - Status bit 0 shows coast input polarity.
// - Mode bit 7 selects dual channel, default one.
// - Mode bit 6 selects parallel output, default one.
// - Mode bit 5 selects first port, default A.
// - Mode bit 0 bypasses internal clock loop.
// - Register zero reads fixed silicon revision.
// - Divider is twelve bits; ratio is value plus one.
// - Only low divider write commits new value.
// - Low divider register bits 7:4 hold LSBs.
// - Divide ratios from 2 to 4095 supported.
// - Divider resets to 1693, high reads 69.
// - Range field bits 7:6, default 01, sets post-divider.
// - Pump field bits 5:3 maps to current, default 001.
module video_digitizer_control_regs
  import vdig_pkg::*;
#(
  // Arbitrary neutral value.
  parameter logic [7:0] SILICON_REVISION = 8'hA5
)
(
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           awvalid,
  output      logic           awready,
  input  wire logic [7:0]     awaddr,
  input  wire logic [2:0]     awprot,
  input  wire logic           wvalid,
  output      logic           wready,
  input  wire logic [31:0]    wdata,
  input  wire logic [3:0]     wstrb,
  output      logic           bvalid,
  input  wire logic           bready,
  output      logic [1:0]     bresp,
  input  wire logic           arvalid,
  output      logic           arready,
  input  wire logic [7:0]     araddr,
  input  wire logic [2:0]     arprot,
  output      logic           rvalid,
  input  wire logic           rready,
  output      logic [31:0]    rdata,
  output      logic [1:0]     rresp,
  input  wire sync_status_t   sync_in,
  input  wire logic [7:0]     test_status_a_in,
  input  wire logic [7:0]     test_status_b_in,
  output      clock_gen_cfg_t clock_cfg,
  output      output_mode_t   output_mode,
  output      logic [7:0]     test_config_a,
  output      logic [7:0]     test_config_b
);

  typedef struct packed {
    logic         aw_full;
    logic [5:0]   aw_idx;
    logic         aw_ok;
    logic         w_full;
    logic [7:0]   w_data;
    logic         w_lane0;
    logic         b_valid;
    logic [1:0]   b_resp;
    logic         r_valid;
    logic [1:0]   r_resp;
    logic [7:0]   r_data;
    sync_status_t sync_status;
    logic [7:0]   div_high;
    logic [3:0]   div_spare;
    logic [11:0]  div_active;
    logic [7:0]   clkgen;
    logic [7:0]   out_mode;
    logic [7:0]   test_a;
    logic [4:0]   test_b;
    logic [7:0]   test_stat_a;
    logic [7:0]   test_stat_b;
    logic [9:0]   pump_ua;
  } state_t;

  localparam state_t STATE_RESET = '{
    aw_full: 1'b0, aw_idx: 6'h00, aw_ok: 1'b0, w_full: 1'b0, w_data: 8'h00, w_lane0: 1'b0,
    b_valid: 1'b0, b_resp: RESP_OKAY, r_valid: 1'b0, r_resp: RESP_OKAY, r_data: 8'h00,
    sync_status: '0, div_high: DIV_HIGH_RESET, div_spare: DIV_SPARE_RESET,
    div_active: DIV_VALUE_RESET, clkgen: CLKGEN_RESET, out_mode: OUT_MODE_RESET,
    test_a: TEST_A_RESET, test_b: TEST_B_RESET, test_stat_a: 8'h00, test_stat_b: 8'h00,
    pump_ua: 10'h064
  };

  state_t state_reg;
  state_t state_next;

  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx <= IDX_CLKGEN) || ((idx >= IDX_SYNC_STATUS) && (idx <= IDX_TEST_STAT_B));
  endfunction

  // Code 111 has no documented current, so it reports zero.
  function automatic logic [9:0] pump_current(input logic [2:0] code);
    unique case (code)
      3'h0: pump_current = 10'h032;
      3'h1: pump_current = 10'h064;
      3'h2: pump_current = 10'h096;
      3'h3: pump_current = 10'h0FA;
      3'h4: pump_current = 10'h15E;
      3'h5: pump_current = 10'h1F4;
      3'h6: pump_current = 10'h2EE;
      3'h7: pump_current = 10'h000;
    endcase
  endfunction

  logic       aw_take;
  logic       w_take;
  logic       do_write;
  logic [5:0] wr_idx;
  logic [7:0] wr_byte;
  logic       wr_en;
  logic       ar_take;
  logic [5:0] rd_idx;

  assign awready = !state_reg.aw_full && !state_reg.b_valid;
  assign wready  = !state_reg.w_full && !state_reg.b_valid;
  assign arready = !state_reg.r_valid;
  assign aw_take = awvalid && awready;
  assign w_take  = wvalid && wready;
  assign ar_take = arvalid && arready;
  assign rd_idx  = araddr[7:2];
  assign wr_idx  = state_reg.aw_full ? state_reg.aw_idx : awaddr[7:2];
  assign wr_byte = state_reg.w_full ? state_reg.w_data : wdata[7:0];
  assign do_write = (state_reg.aw_full || aw_take) && (state_reg.w_full || w_take) && !state_reg.b_valid;
  // Only byte lane 0 carries register data; the upper lanes are read-only zero.
  assign wr_en = do_write && (state_reg.w_full ? state_reg.w_lane0 : wstrb[0]) && is_mapped(wr_idx);

  always_comb
  begin
    state_next = state_reg;
    state_next.sync_status = sync_in;
    state_next.test_stat_a = test_status_a_in;
    state_next.test_stat_b = test_status_b_in;
    state_next.pump_ua = pump_current(state_reg.clkgen[PUMP_LSB +: 3]);
    if (aw_take)
    begin
      state_next.aw_full = 1'b1;
      state_next.aw_idx  = awaddr[7:2];
    end
    if (w_take)
    begin
      state_next.w_full  = 1'b1;
      state_next.w_data  = wdata[7:0];
      state_next.w_lane0 = wstrb[0];
    end
    if (do_write)
    begin
      state_next.aw_full = 1'b0;
      state_next.w_full  = 1'b0;
      state_next.b_valid = 1'b1;
      state_next.b_resp  = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (state_reg.b_valid && bready)
    begin
      state_next.b_valid = 1'b0;
    end
    if (wr_en)
    begin
      // Status, revision and test status indices fall through untouched.
      unique case (wr_idx)
        IDX_DIV_HIGH: state_next.div_high = wr_byte;
        IDX_DIV_LOW:
        begin
          // The pending high byte and the new low nibble take effect together.
          state_next.div_active = {state_reg.div_high, wr_byte[DIV_LOW_LSB +: 4]};
          state_next.div_spare  = wr_byte[3:0];
        end
        IDX_CLKGEN:     state_next.clkgen   = wr_byte;
        IDX_OUT_MODE:   state_next.out_mode = wr_byte;
        IDX_TEST_CFG_A: state_next.test_a   = wr_byte;
        IDX_TEST_CFG_B: state_next.test_b   = wr_byte[TEST_B_LSB +: 5];
        default:        state_next.div_spare = state_reg.div_spare;
      endcase
    end
    if (ar_take)
    begin
      state_next.r_valid = 1'b1;
      state_next.r_resp  = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      unique case (rd_idx)
        IDX_REVISION:    state_next.r_data = SILICON_REVISION;
        IDX_DIV_HIGH:    state_next.r_data = state_reg.div_high;
        IDX_DIV_LOW:     state_next.r_data = {state_reg.div_active[3:0], state_reg.div_spare};
        IDX_CLKGEN:      state_next.r_data = state_reg.clkgen;
        IDX_SYNC_STATUS: state_next.r_data = state_reg.sync_status;
        IDX_OUT_MODE:    state_next.r_data = state_reg.out_mode;
        IDX_TEST_CFG_A:  state_next.r_data = state_reg.test_a;
        IDX_TEST_CFG_B:  state_next.r_data = {state_reg.test_b, 3'h0};
        IDX_TEST_STAT_A: state_next.r_data = state_reg.test_stat_a;
        IDX_TEST_STAT_B: state_next.r_data = state_reg.test_stat_b;
        default:         state_next.r_data = 8'h00;
      endcase
    end
    else if (state_reg.r_valid && rready)
    begin
      state_next.r_valid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign bvalid = state_reg.b_valid;
  assign bresp  = state_reg.b_resp;
  assign rvalid = state_reg.r_valid;
  assign rresp  = state_reg.r_resp;
  assign rdata  = {24'h000000, state_reg.r_data};

  // The ratio is out of range only when software stores 0 or 4095; the loop is still fed.
  assign clock_cfg.divide_ratio = {1'b0, state_reg.div_active} + 13'h0001;
  assign clock_cfg.ratio_in_range = (clock_cfg.divide_ratio >= RATIO_MIN) &&
                                    (clock_cfg.divide_ratio <= RATIO_MAX);
  assign clock_cfg.oscillator_range_field = state_reg.clkgen[RANGE_LSB +: 2];
  assign clock_cfg.post_divide_sel = state_reg.clkgen[RANGE_LSB +: 2];
  assign clock_cfg.pump_current_ua = state_reg.pump_ua;
  assign clock_cfg.internal_loop_off = state_reg.out_mode[MODE_EXT_CLK];
  assign output_mode.dual_channel = state_reg.out_mode[MODE_DUAL];
  assign output_mode.parallel_out = state_reg.out_mode[MODE_PARALLEL];
  assign output_mode.first_port_b = state_reg.out_mode[MODE_PORT_B];
  assign test_config_a = state_reg.test_a;
  assign test_config_b = {state_reg.test_b, 3'h0};

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_low_commits: assert property (wr_en && wr_idx == IDX_DIV_LOW |=>
    state_reg.div_active == {$past(state_reg.div_high), $past(wr_byte[7:4])})
    else $error("Low divider write did not commit the divider.");
  a_high_holds: assert property (wr_en && wr_idx == IDX_DIV_HIGH |=> $stable(clock_cfg.divide_ratio))
    else $error("High divider write changed the active ratio.");
  a_ratio_plus: assert property (wr_en && wr_idx == IDX_DIV_LOW |=>
    clock_cfg.divide_ratio == {1'b0, $past(state_reg.div_high), $past(wr_byte[7:4])} + 13'h0001)
    else $error("Divide ratio is not stored value plus one.");
  a_status_tracks: assert property (##1 state_reg.sync_status == $past(sync_in))
    else $error("Sync status did not follow its inputs.");
  a_revision_read: assert property (ar_take && rd_idx == IDX_REVISION |=> rvalid && rdata[7:0] == SILICON_REVISION)
    else $error("Revision read returned the wrong value.");
  a_status_ro: assert property (wr_en && wr_idx == IDX_SYNC_STATUS |=> $stable(state_reg.out_mode) && $stable(state_reg.div_active))
    else $error("Write to status register changed state.");
  a_pump_map: assert property ((state_reg.clkgen[5:3] == 3'h1) [*2] |-> clock_cfg.pump_current_ua == 10'h064)
    else $error("Pump code 001 did not map to 100 microamps.");
  a_range_post: assert property (clock_cfg.post_divide_sel == state_reg.clkgen[7:6])
    else $error("Post-divider does not follow range field.");
  a_mode_write: assert property (wr_en && wr_idx == IDX_OUT_MODE |=> output_mode.dual_channel == $past(wr_byte[7])
    && clock_cfg.internal_loop_off == $past(wr_byte[0]))
    else $error("Output mode write not applied.");
  a_read_answer: assert property (ar_take |=> rvalid ##0 (rvalid && !rready) [*1] |=> rvalid)
    else $error("Read answer dropped before acceptance.");
  a_write_answer: assert property (do_write |=> bvalid)
    else $error("Write response missing.");

  // Status reads are checked against the pins two cycles back, since the status is registered first.
  a_hsync_read: assert property (ar_take && rd_idx == IDX_SYNC_STATUS |=>
    rdata[7] == $past(sync_in.hsync_present, 2))
    else $error("Hsync present bit read wrongly.");

  a_hsrc_read: assert property (ar_take && rd_idx == IDX_SYNC_STATUS |=>
    rdata[6] == $past(sync_in.active_hsync_source, 2))
    else $error("Hsync source bit read wrongly.");

  a_hpol_read: assert property (ar_take && rd_idx == IDX_SYNC_STATUS |=>
    rdata[5] == $past(sync_in.hsync_polarity_high, 2))
    else $error("Hsync polarity bit read wrongly.");

  a_vsync_read: assert property (ar_take && rd_idx == IDX_SYNC_STATUS |=>
    rdata[4] == $past(sync_in.vsync_present, 2))
    else $error("Vsync present bit read wrongly.");

  a_vsrc_read: assert property (ar_take && rd_idx == IDX_SYNC_STATUS |=>
    rdata[3] == $past(sync_in.active_vsync_source, 2))
    else $error("Vsync source bit read wrongly.");

  a_vpol_read: assert property (ar_take && rd_idx == IDX_SYNC_STATUS |=>
    rdata[2] == $past(sync_in.vsync_out_polarity_low, 2))
    else $error("Vsync polarity bit read wrongly.");

  a_green_read: assert property (ar_take && rd_idx == IDX_SYNC_STATUS |=>
    rdata[1] == $past(sync_in.green_sync_present, 2))
    else $error("Green sync bit read wrongly.");

  a_coast_read: assert property (ar_take && rd_idx == IDX_SYNC_STATUS |=>
    rdata[0] == $past(sync_in.coast_polarity_high, 2))
    else $error("Coast polarity bit read wrongly.");

  a_dual_default: assert property ($rose(aresetn) |->
    output_mode.dual_channel)
    else $error("Dual channel mode not set after reset.");

  a_parallel_default: assert property ($rose(aresetn) |->
    output_mode.parallel_out)
    else $error("Parallel output not set after reset.");

  a_port_default: assert property ($rose(aresetn) |->
    !output_mode.first_port_b)
    else $error("First port is not A after reset.");

  a_extclk_default: assert property ($rose(aresetn) |->
    !clock_cfg.internal_loop_off)
    else $error("Internal loop not in use after reset.");

  a_parallel_write: assert property (wr_en && wr_idx == IDX_OUT_MODE |=>
    output_mode.parallel_out == $past(wr_byte[6]))
    else $error("Parallel output bit not applied.");

  a_port_write: assert property (wr_en && wr_idx == IDX_OUT_MODE |=>
    output_mode.first_port_b == $past(wr_byte[5]))
    else $error("First port bit not applied.");

  a_divider_default: assert property ($rose(aresetn) |->
    clock_cfg.divide_ratio == 13'h069E && state_reg.div_high == 8'h69)
    else $error("Divider not at its reset value.");

  a_range_default: assert property ($rose(aresetn) |->
    clock_cfg.oscillator_range_field == 2'h1)
    else $error("Range field not at its reset value.");

  a_pump_default: assert property ($rose(aresetn) |->
    clock_cfg.pump_current_ua == 10'h064)
    else $error("Pump current not at its reset value.");

  a_range_write: assert property (wr_en && wr_idx == IDX_CLKGEN |=>
    clock_cfg.oscillator_range_field == $past(wr_byte[7:6]))
    else $error("Range field write not applied.");

  a_low_nibble: assert property (ar_take && rd_idx == IDX_DIV_LOW |=>
    rdata[7:4] == $past(state_reg.div_active[3:0]))
    else $error("Low divider nibble read wrongly.");

  a_revision_ro: assert property (wr_en && wr_idx == IDX_REVISION |=>
    $stable(clock_cfg) && $stable(output_mode))
    else $error("Write to revision register changed state.");

  a_ratio_low: assert property (state_reg.div_active == 12'h000 |->
    !clock_cfg.ratio_in_range)
    else $error("Ratio of one reported as supported.");

  a_ratio_top: assert property (state_reg.div_active == 12'hFFE |->
    clock_cfg.ratio_in_range && clock_cfg.divide_ratio == 13'h0FFF)
    else $error("Ratio of 4095 not reported as supported.");

  a_pump_top: assert property ((state_reg.clkgen[5:3] == 3'h6) [*2] |->
    clock_cfg.pump_current_ua == 10'h2EE)
    else $error("Pump code 110 did not map to 750 microamps.");

  a_unmapped_resp: assert property (do_write && !is_mapped(wr_idx) |=>
    bresp == RESP_SLVERR)
    else $error("Unmapped write not answered with an error.");


  c_low_write: cover property (wr_en && wr_idx == IDX_DIV_LOW);
  c_high_then_low: cover property (wr_en && wr_idx == IDX_DIV_HIGH ##[1:20] wr_en && wr_idx == IDX_DIV_LOW);
  c_w_before_aw: cover property (w_take && !aw_take ##[1:5] aw_take);
  c_unmapped_read: cover property (ar_take && !is_mapped(rd_idx));

endmodule

// [tb/video_digitizer_control_regs_bench.sv]
`timescale 1ns/1ps
module video_digitizer_control_regs_bench;
  import vdig_pkg::*;
  // Arbitrary revision value, chosen to differ from the design default.
  localparam logic [7:0] REV = 8'h3C;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, tsa, tsb, tca, tcb;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  sync_status_t sync_in;
  clock_gen_cfg_t cfg;
  output_mode_t mode;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  video_digitizer_control_regs #(.SILICON_REVISION(REV)) u_video_digitizer_control_regs (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .sync_in(sync_in), .test_status_a_in(tsa),
    .test_status_b_in(tsb), .clock_cfg(cfg), .output_mode(mode), .test_config_a(tca), .test_config_b(tcb));

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Ready is sampled at the falling edge so the decision never races the rising edge updates.
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] rs);
    logic ta, tw, done;
    done = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, output logic [33:0] dr);
    logic ta, done;
    done = 0;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      done = rvalid;
      dr = {rresp, rdata};
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [5:0] idx, input logic [7:0] exp);
    logic [33:0] dr;
    rd(idx, dr);
    chk(nm, dr, {RESP_OKAY, 24'h0, exp});
  endtask

  task automatic t_reset;
    @(negedge aclk);
    chk("ratio", cfg.divide_ratio, 13'd1694);
    chk("range", {cfg.oscillator_range_field, cfg.post_divide_sel}, 4'h5);
    chk("pump", cfg.pump_current_ua, 10'd100);
    chk("mode", {mode, cfg.internal_loop_off}, 4'hC);
    rchk("rev", IDX_REVISION, REV);
    rchk("divh", IDX_DIV_HIGH, 8'h69);
    rchk("divl", IDX_DIV_LOW, 8'hD0);
    rchk("clk", IDX_CLKGEN, 8'h48);
    rchk("mode", IDX_OUT_MODE, 8'hC6);
  endtask

  task automatic t_div;
    logic [7:0] hi [4] = '{8'h00, 8'h00, 8'hFF, 8'hFF};
    logic [7:0] lo [4] = '{8'h10, 8'h00, 8'hE0, 8'hF0};
    logic [3:0] ok = 4'b0101;
    wr(IDX_DIV_HIGH, 8'h12, r);
    @(negedge aclk);
    chk("hold", cfg.divide_ratio, 13'd1694);
    rchk("divh", IDX_DIV_HIGH, 8'h12);
    wr(IDX_DIV_LOW, 8'h3F, r);
    @(negedge aclk);
    chk("ratio", cfg.divide_ratio, 13'h124);
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_DIV_HIGH, hi[i], r);
      wr(IDX_DIV_LOW, lo[i], r);
      @(negedge aclk);
      chk("bound", {cfg.divide_ratio, cfg.ratio_in_range}, {{1'b0, hi[i], lo[i][7:4]} + 13'h1, ok[i]});
    end
  endtask

  task automatic t_clk;
    logic [9:0] ua [7] = '{10'd50, 10'd100, 10'd150, 10'd250, 10'd350, 10'd500, 10'd750};
    for (int i = 0; i < 7; i++)
    begin
      wr(IDX_CLKGEN, {i[1:0], i[2:0], 3'h0}, r);
      @(negedge aclk);
      chk("pump", cfg.pump_current_ua, ua[i]);
      chk("range", {cfg.oscillator_range_field, cfg.post_divide_sel}, {i[1:0], i[1:0]});
    end
  endtask

  task automatic t_mode;
    logic [7:0] v [4] = '{8'h00, 8'h80, 8'h40, 8'h21};
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_OUT_MODE, v[i], r);
      @(negedge aclk);
      chk("mode", {mode, cfg.internal_loop_off}, {v[i][7:5], v[i][0]});
    end
  endtask

  task automatic t_status;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge aclk);
      sync_in <= sync_status_t'(8'h01 << i);
      rchk("sync", IDX_SYNC_STATUS, 8'h01 << i);
    end
    wr(IDX_SYNC_STATUS, 8'h00, r);
    rchk("sync", IDX_SYNC_STATUS, 8'h80);
    wr(IDX_REVISION, 8'hFF, r);
    rchk("rev", IDX_REVISION, REV);
    tsa <= 8'h5A;
    tsb <= 8'hC3;
    wr(IDX_TEST_STAT_A, 8'h00, r);
    rchk("tsa", IDX_TEST_STAT_A, 8'h5A);
    rchk("tsb", IDX_TEST_STAT_B, 8'hC3);
  endtask

  task automatic t_test;
    logic [33:0] dr;
    rchk("ta", IDX_TEST_CFG_A, 8'hFF);
    rchk("tb", IDX_TEST_CFG_B, 8'h00);
    wr(IDX_TEST_CFG_A, 8'hFE, r);
    wr(IDX_TEST_CFG_B, 8'h00, r);
    @(negedge aclk);
    chk("tcfg", {tca, tcb}, 16'hFE00);
    wr(IDX_TEST_CFG_B, 8'h00, r);
    @(posedge aclk);
    wstrb <= 4'h0;
    wr(IDX_TEST_CFG_A, 8'h00, r);
    wstrb <= 4'hF;
    chk("strb", {r, tca}, {RESP_OKAY, 8'hFE});
    wr(6'h05, 8'h11, r);
    chk("unmap", r, RESP_SLVERR);
    rd(6'h05, dr);
    chk("unmap", dr, {RESP_SLVERR, 32'h0});
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    sync_in = sync_status_t'(8'h00);
    tsa = 8'h00;
    tsb = 8'h00;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_div;
    t_clk;
    t_mode;
    t_status;
    t_test;
    test_done;
  end

  // A hang is cut short well beyond the few hundred cycles the sequence needs.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      test_done;
    end
  end
endmodule
